/* common/llcs_defs.svh */
// Offsets, field positions, reset values and timing counts of the supervisory sequencer
`ifndef LLCS_DEFS_SVH
`define LLCS_DEFS_SVH

// ======================================================================
// Clock and timing
`define LLCS_CLK_NS            4
`define LLCS_START_BLANK_NS    8000
`define LLCS_START_BLANK_CYC   ((`LLCS_START_BLANK_NS + `LLCS_CLK_NS - 1) / `LLCS_CLK_NS)
`define LLCS_OTP_BLANK_NS      16000
`define LLCS_OTP_BLANK_CYC     ((`LLCS_OTP_BLANK_NS + `LLCS_CLK_NS - 1) / `LLCS_CLK_NS)
`define LLCS_SOFT_START_NS     1000000
`define LLCS_SOFT_START_CYC    ((`LLCS_SOFT_START_NS + `LLCS_CLK_NS - 1) / `LLCS_CLK_NS)
`define LLCS_RECOVERY_NS       1000000000
`define LLCS_RECOVERY_CYC      ((`LLCS_RECOVERY_NS + `LLCS_CLK_NS - 1) / `LLCS_CLK_NS)

// ======================================================================
// Timer channels
`define LLCS_TMR_N             4
`define LLCS_TMR_START         0
`define LLCS_TMR_OTP           1
`define LLCS_TMR_SOFT          2
`define LLCS_TMR_REC           3

// ======================================================================
// Comparator flag positions
`define LLCS_FLAG_N            10
`define LLCS_F_HV              0
`define LLCS_F_RESET           1
`define LLCS_F_OFF             2
`define LLCS_F_ON              3
`define LLCS_F_BULK            4
`define LLCS_F_SKIP_IN         5
`define LLCS_F_SKIP_OUT        6
`define LLCS_F_OVLD            7
`define LLCS_F_OVP             8
`define LLCS_F_OTP             9

// ======================================================================
// Register map
`define LLCS_CTRL_OFS          12'h000
`define LLCS_STATUS_OFS        12'h004
`define LLCS_CTRL_LATCH_BIT    0
`define LLCS_CTRL_RUN_BIT      1
`define LLCS_CTRL_RST          2'h2
`define LLCS_ST_STATE_LSB      0
`define LLCS_ST_FLAG_LSB       4
`define LLCS_ST_FIRST_ON_BIT   14
`define LLCS_ST_DRV_BIT        15

`endif

/* common/llcs_pkg.sv */
// Types of the supervisory sequencer
package llcs_pkg;

   typedef enum logic [3:0] {
      LLCS_OFF,
      LLCS_CHARGE,
      LLCS_WAIT,
      LLCS_SOFT,
      LLCS_RUN,
      LLCS_SKIP,
      LLCS_REC,
      LLCS_BROWN,
      LLCS_LATCH
   } llcs_state_t;

   typedef enum logic [1:0] {
      LLCS_FSM_OFF,
      LLCS_FSM_ACTIVE,
      LLCS_FSM_REG1
   } llcs_fs_mode_t;

endpackage : llcs_pkg

/* common/llcs_tmr_if.sv */
// Start and busy lines between the sequencer and its delay timers
`include "llcs_defs.svh"

interface llcs_tmr_if;
   logic [`LLCS_TMR_N-1:0] go;
   logic [`LLCS_TMR_N-1:0] busy;

   modport seq (output go, input busy);
   modport tmr (input go, output busy);
endinterface : llcs_tmr_if

/* rtl/llcs_timers.sv */
// Blanking, soft-start and recovery delay timers
`include "llcs_defs.svh"

module llcs_timers #(
   parameter int unsigned START_CYC = `LLCS_START_BLANK_CYC,
   parameter int unsigned OTP_CYC   = `LLCS_OTP_BLANK_CYC,
   parameter int unsigned SOFT_CYC  = `LLCS_SOFT_START_CYC,
   parameter int unsigned REC_CYC   = `LLCS_RECOVERY_CYC
) (
   input  wire logic pclk,
   input  wire logic presetn,
   llcs_tmr_if.tmr   tmr
);

   localparam int unsigned LOADS [`LLCS_TMR_N] = '{START_CYC, OTP_CYC, SOFT_CYC, REC_CYC};

   // ======================================================================
   // One down-counter per channel; busy for exactly its load in cycles
   genvar i;
   generate
      for (i = 0; i < `LLCS_TMR_N; i++) begin : g_tmr
         logic [31:0] cnt_r;
         logic [31:0] cnt_nxt;
         assign cnt_nxt = tmr.go[i] ? LOADS[i] : ((cnt_r != 32'h0) ? cnt_r - 32'h1 : 32'h0);
         assign tmr.busy[i] = (cnt_r != 32'h0);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_r <= 32'h0;
            end else begin
               cnt_r <= cnt_nxt;
            end
         end
      end
   endgenerate

endmodule : llcs_timers

/* rtl/llcs_sequencer.sv */
// Supervisory state sequencer with APB control and status registers
//
// Our own choices: the APB slave port and the address map.
`include "llcs_defs.svh"

// Summary of operation
// RQ1 - HV source charges supply until turn-on
// RQ2 - Reset level: bias blocks, start blanking
// RQ3 - Mode output changes at first turn-on
// RQ4 - Stop at turn-on: drivers off, self-supply
// RQ5 - Drivers only when on and fault-free
// RQ6 - Every restart: startup then soft-start
// RQ7 - Overload stops switching, unbiases blocks
// RQ8 - Overload enters self-supply operation
// RQ9 - Overload runs fixed recovery delay
// RQ10 - Recovery end: recharge, rebias, blanking
// RQ11 - Skip level: stop, keep feedback only
// RQ12 - Skip exit: rebias, drivers burst
// RQ13 - Skip keeps HV source off if adequate
// RQ14 - Burst start opens over-temperature blanking
// RQ15 - Bulk low: drivers, fault block off
// RQ16 - Brown-out drives front stage supply level
// RQ17 - Bulk good: recharge, bias, blanking
// RQ18 - Bulk good flag includes hysteresis
// RQ19 - Latch held until below reset level
// RQ20 - Flags synchronized, clocked transitions
// RQ21 - Faults ignored during startup blanking
module llcs_sequencer #(
   parameter int unsigned OTP_CYC  = `LLCS_OTP_BLANK_CYC,
   parameter int unsigned SOFT_CYC = `LLCS_SOFT_START_CYC,
   parameter int unsigned REC_CYC  = `LLCS_RECOVERY_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        high_voltage_input_ok,
   input  wire logic        supply_above_reset_level,
   input  wire logic        supply_above_off_level,
   input  wire logic        supply_above_turn_on_level,
   input  wire logic        bulk_level_good,
   input  wire logic        feedback_at_skip_level,
   input  wire logic        feedback_above_skip_exit,
   input  wire logic        overload_detect,
   input  wire logic        fault_overvoltage,
   input  wire logic        fault_overtemp,
   output logic             half_bridge_drivers_en,
   output logic             bias_all_en,
   output logic             bias_fb_supply_en,
   output logic             fault_input_block_en,
   output logic             hv_source_en,
   output logic             self_supply_mode,
   output llcs_pkg::llcs_fs_mode_t front_stage_mode_out
);

   // ======================================================================
   // Comparator flag synchronisers
   logic [`LLCS_FLAG_N-1:0] raw_flags;
   logic [`LLCS_FLAG_N-1:0] meta_r;
   logic [`LLCS_FLAG_N-1:0] flag_r;

   assign raw_flags = {fault_overtemp, fault_overvoltage, overload_detect,
                       feedback_above_skip_exit, feedback_at_skip_level, bulk_level_good,
                       supply_above_turn_on_level, supply_above_off_level,
                       supply_above_reset_level, high_voltage_input_ok};

   genvar g;
   generate
      for (g = 0; g < `LLCS_FLAG_N; g++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_r[g] <= 1'b0;
               flag_r[g] <= 1'b0;
            end else begin
               meta_r[g] <= raw_flags[g];         // [RQ20]
               flag_r[g] <= meta_r[g];
            end
         end
      end
   endgenerate

   wire s_hv      = flag_r[`LLCS_F_HV];
   wire s_reset   = flag_r[`LLCS_F_RESET];
   wire s_off_ok  = flag_r[`LLCS_F_OFF];
   wire s_on      = flag_r[`LLCS_F_ON];
   wire s_bulk    = flag_r[`LLCS_F_BULK];        // Comparator already carries hysteresis [RQ18]
   wire s_skip_in = flag_r[`LLCS_F_SKIP_IN];
   wire s_skip_ex = flag_r[`LLCS_F_SKIP_OUT];
   wire s_ovld    = flag_r[`LLCS_F_OVLD];
   wire s_ovp     = flag_r[`LLCS_F_OVP];
   wire s_otp     = flag_r[`LLCS_F_OTP];

   // ======================================================================
   // Timers
   llcs_tmr_if tmr_if ();

   llcs_timers #(
      .START_CYC (`LLCS_START_BLANK_CYC),
      .OTP_CYC   (OTP_CYC),
      .SOFT_CYC  (SOFT_CYC),
      .REC_CYC   (REC_CYC)
   ) u_timers (
      .pclk    (pclk),
      .presetn (presetn),
      .tmr     (tmr_if.tmr)
   );

   wire start_busy = tmr_if.busy[`LLCS_TMR_START];
   wire otp_busy   = tmr_if.busy[`LLCS_TMR_OTP];
   wire soft_busy  = tmr_if.busy[`LLCS_TMR_SOFT];
   wire rec_busy   = tmr_if.busy[`LLCS_TMR_REC];

   // ======================================================================
   // Control register
   logic [1:0] ctrl_r;
   wire latch_mode = ctrl_r[`LLCS_CTRL_LATCH_BIT];
   wire run_en     = ctrl_r[`LLCS_CTRL_RUN_BIT];

   // ======================================================================
   // Sequencer
   llcs_pkg::llcs_state_t state_r;
   llcs_pkg::llcs_state_t state_nxt;
   logic                  first_on_r;
   logic                  first_on_nxt;

   // Faults count only after startup blanking, OTP also after burst blanking
   wire faults_live = !start_busy && (s_ovld || (fault_input_block_en &&
                      (s_ovp || (s_otp && !otp_busy))));         // [RQ21] [RQ14]
   wire ext_fault   = !start_busy && fault_input_block_en &&
                      (s_ovp || (s_otp && !otp_busy));
   wire stop_cond   = !s_bulk || !run_en;
   wire charge_done = (state_r == llcs_pkg::LLCS_CHARGE) && !start_busy && s_on;

   always_comb begin
      state_nxt = state_r;
      if (!s_reset) begin
         state_nxt = llcs_pkg::LLCS_OFF;                          // [RQ19]
      end else begin
         case (state_r)
            llcs_pkg::LLCS_OFF: begin
               state_nxt = llcs_pkg::LLCS_CHARGE;                // [RQ2]
            end
            llcs_pkg::LLCS_CHARGE: begin
               if (charge_done) begin
                  if (stop_cond || faults_live) begin
                     state_nxt = llcs_pkg::LLCS_WAIT;            // [RQ4]
                  end else begin
                     state_nxt = llcs_pkg::LLCS_SOFT;            // [RQ5] [RQ6]
                  end
               end
            end
            llcs_pkg::LLCS_WAIT: begin
               if (s_bulk && run_en && !faults_live) begin
                  state_nxt = llcs_pkg::LLCS_CHARGE;             // [RQ17]
               end
            end
            llcs_pkg::LLCS_SOFT, llcs_pkg::LLCS_RUN: begin
               if (!s_bulk) begin
                  state_nxt = llcs_pkg::LLCS_BROWN;              // [RQ15]
               end else if (ext_fault && latch_mode) begin
                  state_nxt = llcs_pkg::LLCS_LATCH;
               end else if (faults_live || !run_en) begin
                  state_nxt = llcs_pkg::LLCS_REC;                // [RQ7] [RQ9]
               end else if (state_r == llcs_pkg::LLCS_SOFT) begin
                  if (!soft_busy) begin
                     state_nxt = llcs_pkg::LLCS_RUN;
                  end
               end else if (s_skip_in) begin
                  state_nxt = llcs_pkg::LLCS_SKIP;               // [RQ11]
               end
            end
            llcs_pkg::LLCS_SKIP: begin
               if (s_skip_ex) begin
                  state_nxt = llcs_pkg::LLCS_RUN;                // [RQ12]
               end
            end
            llcs_pkg::LLCS_REC: begin
               if (!rec_busy) begin
                  state_nxt = llcs_pkg::LLCS_CHARGE;             // [RQ10]
               end
            end
            llcs_pkg::LLCS_BROWN: begin
               if (s_bulk) begin
                  state_nxt = llcs_pkg::LLCS_CHARGE;             // [RQ17]
               end
            end
            llcs_pkg::LLCS_LATCH: begin
               state_nxt = llcs_pkg::LLCS_LATCH;                  // [RQ19]
            end
            default: begin
               state_nxt = llcs_pkg::LLCS_OFF;
            end
         endcase
      end
   end

   wire entering = (state_nxt != state_r);
   assign tmr_if.go[`LLCS_TMR_START] = entering && (state_nxt == llcs_pkg::LLCS_CHARGE);
   assign tmr_if.go[`LLCS_TMR_SOFT]  = entering && (state_nxt == llcs_pkg::LLCS_SOFT);
   assign tmr_if.go[`LLCS_TMR_REC]   = entering && (state_nxt == llcs_pkg::LLCS_REC);
   assign tmr_if.go[`LLCS_TMR_OTP]   = entering && (state_r == llcs_pkg::LLCS_SKIP); // [RQ14]

   assign first_on_nxt = (state_nxt == llcs_pkg::LLCS_OFF) ? 1'b0 : (first_on_r || charge_done);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r    <= llcs_pkg::LLCS_OFF;
         first_on_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         first_on_r <= first_on_nxt;                              // [RQ3]
      end
   end

   // ======================================================================
   // Output decode
   wire st_off   = (state_r == llcs_pkg::LLCS_OFF);
   wire st_drv   = (state_r == llcs_pkg::LLCS_SOFT) || (state_r == llcs_pkg::LLCS_RUN);
   wire st_dss   = (state_r == llcs_pkg::LLCS_WAIT) || (state_r == llcs_pkg::LLCS_REC) ||
                   (state_r == llcs_pkg::LLCS_BROWN) || (state_r == llcs_pkg::LLCS_LATCH);
   wire st_quiet = (state_r == llcs_pkg::LLCS_SKIP) || (state_r == llcs_pkg::LLCS_REC) ||
                   (state_r == llcs_pkg::LLCS_LATCH);

   assign half_bridge_drivers_en = st_drv;                        // [RQ5]
   assign bias_all_en            = !st_off && !st_quiet;          // [RQ7] [RQ11]
   assign bias_fb_supply_en      = !st_off;
   assign fault_input_block_en   = bias_all_en && (state_r != llcs_pkg::LLCS_BROWN); // [RQ15]
   assign self_supply_mode       = st_dss;                        // [RQ8]
   // Off state refills whenever HV is ok, skip only below the off level, charge and self-supply only below turn-on
   assign hv_source_en = st_off ? s_hv :                          // [RQ1]
                         (state_r == llcs_pkg::LLCS_SKIP) ? !s_off_ok :  // [RQ13]
                         (st_dss || (state_r == llcs_pkg::LLCS_CHARGE)) ? !s_on : 1'b0;
   assign front_stage_mode_out =
      (state_r == llcs_pkg::LLCS_BROWN) ? llcs_pkg::LLCS_FSM_REG1 :      // [RQ16]
      first_on_r ? llcs_pkg::LLCS_FSM_ACTIVE : llcs_pkg::LLCS_FSM_OFF;  // [RQ3]

   // ======================================================================
   // APB slave, zero wait states, read data captured in the setup cycle
   wire        setup    = psel && !penable;
   wire        hit_ctrl = (paddr == `LLCS_CTRL_OFS);
   wire        hit_stat = (paddr == `LLCS_STATUS_OFS);
   wire        wr_ctrl  = psel && penable && pwrite && hit_ctrl;
   wire [31:0] status_w;
   wire [31:0] rd_mux;
   logic [31:0] prdata_r;
   logic        err_r;

   assign status_w = {16'h0, half_bridge_drivers_en, first_on_r, flag_r, state_r};
   assign rd_mux   = hit_ctrl ? {30'h0, ctrl_r} : (hit_stat ? status_w : 32'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r   <= `LLCS_CTRL_RST;
         prdata_r <= 32'h0;
         err_r    <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= pwdata[1:0];
         end
         if (setup) begin
            prdata_r <= pwrite ? 32'h0 : rd_mux;
            err_r    <= !(hit_ctrl || (hit_stat && !pwrite));
         end
      end
   end

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && err_r;

   // ======================================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_OFF_HV: assert property (st_off && s_hv |-> hv_source_en) // [RQ1]
      else $error("HV source off while supply below reset level");
   AST_BLANK_START: assert property (st_off && s_reset |=> // [RQ2]
      state_r == llcs_pkg::LLCS_CHARGE && start_busy && bias_all_en)
      else $error("No blanking window at reset level");
   AST_MODE_FIRST: assert property (charge_done && s_reset |=> // [RQ3]
      front_stage_mode_out != llcs_pkg::LLCS_FSM_OFF)
      else $error("Front stage mode not changed at turn-on");
   AST_WAIT_DSS: assert property (state_r == llcs_pkg::LLCS_WAIT |-> // [RQ4]
      !half_bridge_drivers_en && bias_all_en && self_supply_mode)
      else $error("Stop condition wait state wrong");
   AST_DRV_AUTH: assert property ($rose(half_bridge_drivers_en) && // [RQ5]
      $past(state_r) == llcs_pkg::LLCS_CHARGE |-> $past(s_on) && $past(s_bulk))
      else $error("Drivers enabled without turn-on and bulk good");
   AST_SOFT_FIRST: assert property (state_r == llcs_pkg::LLCS_CHARGE ##1 // [RQ6]
      half_bridge_drivers_en |-> state_r == llcs_pkg::LLCS_SOFT && soft_busy)
      else $error("Restart skipped soft-start");
   AST_OVLD_STOP: assert property (st_drv && s_bulk && !start_busy && s_ovld && // [RQ7] [RQ8]
      s_reset |=> !half_bridge_drivers_en && !bias_all_en && self_supply_mode)
      else $error("Overload did not stop switching");
   AST_REC_HOLD: assert property ($rose(state_r == llcs_pkg::LLCS_REC) && s_reset // [RQ9]
      |-> (state_r == llcs_pkg::LLCS_REC)[*8])
      else $error("Recovery delay cut short");
   AST_REC_EXIT: assert property (state_r == llcs_pkg::LLCS_REC && !rec_busy && s_reset // [RQ10]
      |=> state_r == llcs_pkg::LLCS_CHARGE && start_busy && bias_all_en)
      else $error("Recovery end did not restart");
   AST_SKIP_GATE: assert property (state_r == llcs_pkg::LLCS_SKIP |-> // [RQ11]
      !half_bridge_drivers_en && !bias_all_en && bias_fb_supply_en)
      else $error("Skip mode gating wrong");
   AST_SKIP_BURST: assert property (state_r == llcs_pkg::LLCS_SKIP && s_skip_ex // [RQ12] [RQ14]
      && s_reset |=> half_bridge_drivers_en && bias_all_en && otp_busy)
      else $error("Skip exit burst wrong");
   AST_SKIP_HV: assert property (state_r == llcs_pkg::LLCS_SKIP && s_off_ok |-> // [RQ13]
      !hv_source_en)
      else $error("HV source on during skip");
   AST_BROWN: assert property (st_drv && !s_bulk && s_reset |=> // [RQ15] [RQ16]
      state_r == llcs_pkg::LLCS_BROWN && !fault_input_block_en && !half_bridge_drivers_en
      && front_stage_mode_out == llcs_pkg::LLCS_FSM_REG1)
      else $error("Brown-out entry wrong");
   AST_BROWN_EXIT: assert property (state_r == llcs_pkg::LLCS_BROWN && s_bulk // [RQ17]
      && s_reset |=> state_r == llcs_pkg::LLCS_CHARGE && start_busy)
      else $error("Bulk good did not restart");
   AST_LATCH_HOLD: assert property (state_r == llcs_pkg::LLCS_LATCH && s_reset // [RQ19]
      |=> state_r == llcs_pkg::LLCS_LATCH)
      else $error("Latch released above reset level");
   AST_BLANK_MASK: assert property (start_busy && s_ovld && s_reset |=> // [RQ21]
      state_r != llcs_pkg::LLCS_REC && state_r != llcs_pkg::LLCS_LATCH)
      else $error("Fault acted during startup blanking");

   COV_RUN: cover property (state_r == llcs_pkg::LLCS_SOFT ##1 state_r == llcs_pkg::LLCS_RUN);
   COV_SKIP: cover property (state_r == llcs_pkg::LLCS_SKIP ##1 state_r == llcs_pkg::LLCS_RUN);
   COV_REC: cover property (state_r == llcs_pkg::LLCS_REC ##1 state_r == llcs_pkg::LLCS_CHARGE);
   COV_BROWN: cover property (state_r == llcs_pkg::LLCS_BROWN ##1
      state_r == llcs_pkg::LLCS_CHARGE);

endmodule : llcs_sequencer

/* sim/llcs_supply_model.sv */
// Supply capacitor and its threshold comparators seen by the sequencer
module llcs_supply_model (
   input  wire logic pclk,
   input  wire logic plugged,
   input  wire logic fast,
   input  wire logic hv_source_en,
   input  wire logic drv_en,
   output logic      above_reset,
   output logic      above_off,
   output logic      above_on
);
   timeunit 1ns;
   timeprecision 1ps;
   int v = 0;

   // HV source or auxiliary winding refills, otherwise the load drains
   always @(posedge pclk) begin
      if (plugged && hv_source_en)
         v <= (v > 96) ? 100 : v + (fast ? 4 : 1);
      else if (drv_en)
         v <= (v > 99) ? 100 : v + 1;
      else if (v > 0)
         v <= v - 1;
   end

   assign above_reset = v >= 10;
   assign above_off   = v >= 40;
   assign above_on    = v >= 60;
endmodule : llcs_supply_model

/* sim/tb_llc_supervisory_sequencer.sv */
// Self-checking bench for the supervisory sequencer
`include "llcs_defs.svh"

module tb_llc_supervisory_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] r; logic e;} llcs_row_t;
   localparam int REC = 16;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        hv_ok, plugged, fast, s_rst, s_off, s_on, bulk, fb_skip, fb_exit;
   logic        ovl, ovp, ovt, drv, bias_all, bias_fb, fblk, hv_en, ss, er;
   llcs_pkg::llcs_fs_mode_t fsm;
   int          n_fail, n_compared, cnt;
   llcs_row_t   rows [8] = '{
      '{12'h000, 1'b0, 32'h0, 32'h2, 1'b0}, '{12'h000, 1'b1, 32'hffffffff, 32'h0, 1'b0},
      '{12'h000, 1'b0, 32'h0, 32'h3, 1'b0}, '{12'h004, 1'b1, 32'h0, 32'h0, 1'b1},
      '{12'h008, 1'b0, 32'h0, 32'h0, 1'b1}, '{12'h000, 1'b1, 32'h2, 32'h0, 1'b0},
      '{12'h000, 1'b0, 32'h0, 32'h2, 1'b0}, '{12'h004, 1'b0, 32'h0, 32'h0, 1'b0}};

   llcs_sequencer #(.OTP_CYC(20), .SOFT_CYC(20), .REC_CYC(REC)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .high_voltage_input_ok(hv_ok), .supply_above_reset_level(s_rst),
      .supply_above_off_level(s_off), .supply_above_turn_on_level(s_on),
      .bulk_level_good(bulk), .feedback_at_skip_level(fb_skip),
      .feedback_above_skip_exit(fb_exit), .overload_detect(ovl), .fault_overvoltage(ovp),
      .fault_overtemp(ovt), .half_bridge_drivers_en(drv), .bias_all_en(bias_all),
      .bias_fb_supply_en(bias_fb), .fault_input_block_en(fblk), .hv_source_en(hv_en),
      .self_supply_mode(ss), .front_stage_mode_out(fsm));
   llcs_supply_model model (.pclk(pclk), .plugged(plugged), .fast(fast),
      .hv_source_en(hv_en), .drv_en(drv), .above_reset(s_rst), .above_off(s_off),
      .above_on(s_on));

   // ==================================================================
   // Helpers
   task automatic end_of_test();
      if (n_fail == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask : chk

   function automatic bit ok(int s);
      case (s)
         0: return bias_all === 1'b1;
         1: return fsm === llcs_pkg::LLCS_FSM_ACTIVE;
         2: return drv === 1'b1;
         3: return drv === 1'b0;
         default: return fsm === llcs_pkg::LLCS_FSM_OFF;
      endcase
   endfunction : ok

   // Bounded wait on a condition, sampled between edges
   task automatic wt(int s, int lim);
      cnt = 0;
      @(negedge pclk);
      while (!ok(s) && cnt < lim) begin
         @(negedge pclk);
         cnt++;
      end
      chk($sformatf("wait%0d", s), 1, ok(s));
   endtask : wt

   task automatic apb(logic [11:0] a, logic w, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic stchk(logic [3:0] e);
      apb(`LLCS_STATUS_OFS, 1'b0, 32'h0);
      chk("state", e, rd[3:0]);
   endtask : stchk

   // ==================================================================
   // Clock, watchdog and tests
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   initial begin
      repeat (40000) @(posedge pclk);
      n_fail++;
      end_of_test();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {hv_ok, plugged, fast, bulk, fb_skip, fb_exit, ovl, ovp, ovt} = '0;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("outs", 0, {drv, bias_all, bias_fb, fblk, hv_en, ss, fsm});
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         chk("pslverr", rows[i].e, er);
         if (!rows[i].w)
            chk("prdata", rows[i].r, rd);
      end
      @(posedge pclk);
      hv_ok <= 1'b1;
      plugged <= 1'b1;
      wt(0, 300);
      chk("hv_src", 1, hv_en);
      ovl <= 1'b1;
      repeat (5) @(posedge pclk);
      ovl <= 1'b0;
      wt(1, 3000);
      chk("wait_outs", 3'b011, {drv, bias_all, ss});
      stchk(4'h2);
      apb(`LLCS_CTRL_OFS, 1'b1, 32'h0);
      bulk <= 1'b1;
      repeat (20) @(posedge pclk);
      stchk(4'h2);
      fast <= 1'b1;
      apb(`LLCS_CTRL_OFS, 1'b1, 32'h2);
      repeat (100) @(negedge pclk);
      chk("blank_drv", 0, drv);
      wt(2, 3000);
      stchk(4'h3);
      repeat (30) @(negedge pclk);
      stchk(4'h4);
      fb_skip <= 1'b1;
      wt(3, 10);
      chk("skip_bias", 3'b010, {bias_all, bias_fb, hv_en});
      @(posedge pclk);
      fb_skip <= 1'b0;
      fb_exit <= 1'b1;
      ovt <= 1'b1;
      wt(2, 10);
      chk("burst_bias", 1, bias_all);
      repeat (8) @(posedge pclk);
      ovt <= 1'b0;
      fb_exit <= 1'b0;
      repeat (10) @(negedge pclk);
      chk("otp_mask", 1, drv);
      @(posedge pclk);
      bulk <= 1'b0;
      wt(3, 10);
      chk("bo", {2'b01, llcs_pkg::LLCS_FSM_REG1}, {fblk, ss, fsm});
      @(posedge pclk);
      bulk <= 1'b1;
      repeat (5) @(negedge pclk);
      stchk(4'h1);
      wt(2, 3000);
      repeat (30) @(posedge pclk);
      ovl <= 1'b1;
      wt(3, 10);
      chk("ovl_outs", 2'b01, {bias_all, ss});
      @(posedge pclk);
      ovl <= 1'b0;
      wt(0, 100);
      chk("rec_delay", 1, cnt >= REC - 2 && cnt <= REC + 3);
      wt(2, 3000);
      apb(`LLCS_CTRL_OFS, 1'b1, 32'h3);
      repeat (30) @(posedge pclk);
      ovp <= 1'b1;
      wt(3, 10);
      @(posedge pclk);
      ovp <= 1'b0;
      repeat (100) @(negedge pclk);
      stchk(4'h8);
      plugged <= 1'b0;
      hv_ok <= 1'b0;
      wt(4, 500);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(`LLCS_CTRL_OFS, 1'b0, 32'h0);
      chk("ctrl_rst", `LLCS_CTRL_RST, rd);
      end_of_test();
   end
endmodule : tb_llc_supervisory_sequencer
